// *** src/rtcad_pkg.sv ***
// constants and carrier types for the alarm, interrupt and divider block
package rtcad_pkg;
  // ==========================================================
  // widths
  localparam int          RTCAD_ADDR_W    = 6;
  localparam int          RTCAD_DATA_W    = 8;
  localparam int          RTCAD_DIV_W     = 22;
  localparam int          RTCAD_MEM_DEPTH = 64;
  // ==========================================================
  // address map
  localparam logic [5:0]  RTCAD_A_SEC      = 6'h00;
  localparam logic [5:0]  RTCAD_A_SEC_ALM  = 6'h01;
  localparam logic [5:0]  RTCAD_A_MIN      = 6'h02;
  localparam logic [5:0]  RTCAD_A_MIN_ALM  = 6'h03;
  localparam logic [5:0]  RTCAD_A_HR       = 6'h04;
  localparam logic [5:0]  RTCAD_A_HR_ALM   = 6'h05;
  localparam logic [5:0]  RTCAD_A_TIME_END = 6'h09;
  localparam logic [5:0]  RTCAD_A_CTRL_A   = 6'h0a;
  localparam logic [5:0]  RTCAD_A_CTRL_B   = 6'h0b;
  localparam logic [5:0]  RTCAD_A_FLAGS    = 6'h0c;
  localparam logic [5:0]  RTCAD_A_STAT_D   = 6'h0d;
  // ==========================================================
  // field positions
  localparam int          RTCAD_A_UIP_BIT  = 7;
  localparam int          RTCAD_B_SET_BIT  = 7;
  localparam int          RTCAD_B_PIE_BIT  = 6;
  localparam int          RTCAD_B_AIE_BIT  = 5;
  localparam int          RTCAD_B_UIE_BIT  = 4;
  localparam int          RTCAD_B_SQUARE_WAVE_ENABLE_BIT = 3;
  localparam int          RTCAD_SEC_HI_BIT = 7;
  // ==========================================================
  // divider select codes and stage increments
  localparam logic [2:0]  RTCAD_DV_FAST  = 3'h0;
  localparam logic [2:0]  RTCAD_DV_MID   = 3'h1;
  localparam logic [2:0]  RTCAD_DV_SLOW  = 3'h2;
  localparam logic [2:0]  RTCAD_DV_HOLD  = 3'h6;
  localparam logic [21:0] RTCAD_INC_FAST = 22'h000001;
  localparam logic [21:0] RTCAD_INC_MID  = 22'h000004;
  localparam logic [21:0] RTCAD_INC_SLOW = 22'h000080;
  localparam logic [21:0] RTCAD_DIV_HALF = 22'h200000;
  // ==========================================================
  // rate selector tap mapping
  localparam logic [3:0]  RTCAD_RS_OFF       = 4'h0;
  localparam logic [3:0]  RTCAD_RS_SLOW_LIM  = 4'h3;
  localparam logic [4:0]  RTCAD_TAP_OFS_FAST = 5'h05;
  localparam logic [4:0]  RTCAD_TAP_OFS_SLOW = 5'h0c;
  // ==========================================================
  // alarm wildcard and reset values
  localparam logic [1:0]  RTCAD_WILD_TOP = 2'h3;
  localparam logic [2:0]  RTCAD_RST_DV   = 3'h6;
  localparam logic [3:0]  RTCAD_RST_RS   = 4'h0;
  localparam logic [7:0]  RTCAD_RST_B    = 8'h00;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rtcad_bus_type;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
  } rtcad_time_type;
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } rtcad_tload_type;
endpackage

// *** src/rtcad_core.sv ***
// alarm match, interrupt flags, divider chain and rate selector
`timescale 1ns/1ps
// Operation
// - alarm byte with both top bits set matches any time value
// - specific alarm time raises alarm daily; interrupt only when enabled
// - wildcards give hourly, per-minute or per-second alarms
// - fifty storage bytes untouched by clock logic, always accessible
// - held divider stops interrupts and square wave; set bit does not
// - held divider lets time bytes act as storage; some bits excluded
// - each source has its own interrupt enable bit
// - enabling a source whose flag is set asserts interrupt at once
// - flags set on events regardless of enables
// - reading flag register clears bits that read as one
// - flag read value stable; events during read are kept
// - interrupt low while any flag and enable pair set; bit 7 shows it
// - 22 binary stages produce the 1 Hz update strobe
// - codes 000/001/010 pick time base; 110/111 hold divider reset
// - first update strobe half a second after divider release
// - four-bit rate code picks one of 15 taps, zero gives none
// - square wave and periodic interrupt have separate enables
// - fast bases give 30.517 us to 500 ms, 32.768 kHz to 2 Hz
// - slow base codes 1 and 2 give 256 Hz and 128 Hz
// - interrupt line released when no enabled flag is set
// - reset clears enables, flags, square-wave enable, releases line
module rtcad_core (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // time base, one pulse per oscillator cycle
  input  wire logic                     osc_tick,
  // register port
  input  wire rtcad_pkg::rtcad_bus_type bus,
  output logic [7:0]                    rdata,
  // neighbouring update and calendar logic
  input  wire rtcad_pkg::rtcad_time_type time_now,
  input  wire logic                     update_in_progress,
  input  wire logic                     update_done,
  input  wire logic                     ram_valid,
  output logic                          tick_1hz,
  output logic                          update_inhibit,
  output rtcad_pkg::rtcad_tload_type    time_load,
  // pins
  output logic                          irq_n_o,
  output logic                          irq_oe,
  output logic                          square_wave_out
);
  import rtcad_pkg::*;

  // ==========================================================
  // state
  logic [2:0]                 dv_q;
  logic [3:0]                 rs_q;
  logic [7:0]                 ctrl_b_q;
  logic                       pf_q;
  logic                       af_q;
  logic                       uf_q;
  logic [RTCAD_DIV_W-1:0]     div_q;
  logic                       tap_prev_q;
  logic [7:0]                 mem [RTCAD_MEM_DEPTH];
  logic                       running;
  logic                       slow_base;
  logic [RTCAD_DIV_W-1:0]     div_inc;
  logic [RTCAD_DIV_W:0]       div_sum;
  logic [4:0]                 tap_idx;
  logic                       tap;
  logic                       pf_event;
  logic                       af_event;
  logic                       uf_event;
  logic                       alarm_match;
  logic                       flags_read;
  logic                       irq_any;
  logic                       ctrl_write;
  logic                       periodic_int_enable;
  logic                       alarm_int_enable;
  logic                       update_done_int_enable;
  logic                       square_wave_enable;

  // ==========================================================
  // divider control
  // only the three operating codes run; reset and test codes hold
  always_comb begin
    running   = 1'b0;
    slow_base = 1'b0;
    div_inc   = RTCAD_INC_FAST;
    unique case (dv_q)
      RTCAD_DV_FAST: begin
        running = 1'b1;
      end
      RTCAD_DV_MID: begin
        running = 1'b1;
        div_inc = RTCAD_INC_MID;
      end
      RTCAD_DV_SLOW: begin
        running   = 1'b1;
        slow_base = 1'b1;
        div_inc   = RTCAD_INC_SLOW;
      end
      default: begin
        running = 1'b0;
      end
    endcase
  end

  assign div_sum = {1'b0, div_q} + {1'b0, div_inc};

  // 22-stage chain, preset to half while held so release waits 0.5 s
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_q <= RTCAD_DIV_HALF;
    end else if (!running) begin
      div_q <= RTCAD_DIV_HALF;
    end else if (osc_tick) begin
      div_q <= div_sum[RTCAD_DIV_W-1:0];
    end
  end

  // update strobe on carry out of the last stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_1hz <= 1'b0;
    end else begin
      tick_1hz <= running & osc_tick & div_sum[RTCAD_DIV_W];
    end
  end

  // ==========================================================
  // 1-of-15 rate selector shared by periodic flag and square wave
  always_comb begin
    if (slow_base && (rs_q < RTCAD_RS_SLOW_LIM)) begin
      tap_idx = 5'(rs_q) + RTCAD_TAP_OFS_SLOW;
    end else begin
      tap_idx = 5'(rs_q) + RTCAD_TAP_OFS_FAST;
    end
    tap = (rs_q != RTCAD_RS_OFF) && running && div_q[tap_idx];
  end

  // previous tap level for end-of-interval detection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tap_prev_q <= 1'b0;
    end else begin
      tap_prev_q <= tap;
    end
  end

  // square wave only while enabled and divider runs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      square_wave_out <= 1'b0;
    end else begin
      square_wave_out <= square_wave_enable & tap;
    end
  end

  // ==========================================================
  // events
  always_comb begin
    alarm_match = 1'b1;
    if (mem[RTCAD_A_SEC_ALM][7:6] != RTCAD_WILD_TOP &&
        mem[RTCAD_A_SEC_ALM] != time_now.sec) begin
      alarm_match = 1'b0;
    end
    if (mem[RTCAD_A_MIN_ALM][7:6] != RTCAD_WILD_TOP &&
        mem[RTCAD_A_MIN_ALM] != time_now.min) begin
      alarm_match = 1'b0;
    end
    if (mem[RTCAD_A_HR_ALM][7:6] != RTCAD_WILD_TOP &&
        mem[RTCAD_A_HR_ALM] != time_now.hr) begin
      alarm_match = 1'b0;
    end
  end

  assign pf_event = tap_prev_q & ~tap & running;
  assign uf_event = update_done & running;
  assign af_event = uf_event & alarm_match;

  // ==========================================================
  // flags: read clears, a coincident event wins over the clear
  assign flags_read = bus.rd && (bus.addr == RTCAD_A_FLAGS);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pf_q <= 1'b0;
      af_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      pf_q <= (pf_q & ~flags_read) | pf_event;
      af_q <= (af_q & ~flags_read) | af_event;
      uf_q <= (uf_q & ~flags_read) | uf_event;
    end
  end

  // ==========================================================
  // interrupt line, open drain
  assign periodic_int_enable     = ctrl_b_q[RTCAD_B_PIE_BIT];
  assign alarm_int_enable     = ctrl_b_q[RTCAD_B_AIE_BIT];
  assign update_done_int_enable     = ctrl_b_q[RTCAD_B_UIE_BIT];
  assign square_wave_enable    = ctrl_b_q[RTCAD_B_SQUARE_WAVE_ENABLE_BIT];
  assign irq_any = (pf_q & periodic_int_enable) | (af_q & alarm_int_enable) | (uf_q & update_done_int_enable);
  assign irq_oe  = irq_any;
  assign irq_n_o = 1'b0;    // drives low only when enabled

  // ==========================================================
  // control registers
  assign ctrl_write = bus.wr;
  assign update_inhibit = ctrl_b_q[RTCAD_B_SET_BIT];

  // divider and rate select
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dv_q <= RTCAD_RST_DV;
      rs_q <= RTCAD_RST_RS;
    end else if (ctrl_write && bus.addr == RTCAD_A_CTRL_A) begin
      dv_q <= bus.wdata[6:4];
      rs_q <= bus.wdata[3:0];
    end
  end

  // enables and mode bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_b_q <= RTCAD_RST_B;
    end else if (ctrl_write && bus.addr == RTCAD_A_CTRL_B) begin
      ctrl_b_q <= bus.wdata;
    end
  end

  // ==========================================================
  // storage bytes, never touched by clock logic
  always_ff @(posedge clk_sys) begin
    if (ctrl_write && bus.addr != RTCAD_A_CTRL_A &&
        bus.addr != RTCAD_A_CTRL_B && bus.addr != RTCAD_A_FLAGS &&
        bus.addr != RTCAD_A_STAT_D) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  // time byte writes forwarded to the calendar logic
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      time_load <= '0;
    end else begin
      time_load.valid <= ctrl_write && (bus.addr <= RTCAD_A_TIME_END);
      time_load.addr  <= bus.addr;
      time_load.data  <= bus.wdata;
    end
  end

  // ==========================================================
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (!bus.rd) begin
      rdata <= '0;
    end else begin
      unique case (bus.addr)
        RTCAD_A_CTRL_A: rdata <= {update_in_progress, dv_q, rs_q};
        RTCAD_A_CTRL_B: rdata <= ctrl_b_q;
        RTCAD_A_FLAGS:  rdata <= {irq_any, pf_q, af_q, uf_q, 4'h0};
        RTCAD_A_STAT_D: rdata <= {ram_valid, 7'h00};
        RTCAD_A_SEC: begin
          if (running) begin
            rdata <= time_now.sec;
          end else begin
            rdata <= {1'b0, mem[RTCAD_A_SEC][6:0]};
          end
        end
        RTCAD_A_MIN: rdata <= running ? time_now.min : mem[RTCAD_A_MIN];
        RTCAD_A_HR:  rdata <= running ? time_now.hr : mem[RTCAD_A_HR];
        default:     rdata <= mem[bus.addr];
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic [2:0] pend_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 3'h0;
    end else begin
      pend_q <= {pf_event, af_event, uf_event};
    end
  end

  a_flag_read_clear: assert property (
    flags_read && !pf_event && !af_event && !uf_event
      |=> !pf_q && !af_q && !uf_q && !irq_oe)
    else $error("flags not cleared by read");
  a_event_kept: assert property (
    flags_read && pf_event |=> pf_q ##0 rdata[RTCAD_B_PIE_BIT] == $past(pf_q))
    else $error("event lost during flag read");
  a_irq_level: assert property (
    irq_oe == ((pf_q && periodic_int_enable) || (af_q && alarm_int_enable) || (uf_q && update_done_int_enable)))
    else $error("interrupt line disagrees with flags");
  a_irq_release: assert property (
    !pf_q && !af_q && !uf_q |-> !irq_oe)
    else $error("interrupt driven with no flag");
  a_enable_now: assert property (
    ctrl_write && bus.addr == RTCAD_A_CTRL_B && bus.wdata[RTCAD_B_UIE_BIT]
      && uf_q && !flags_read |=> irq_oe)
    else $error("set flag not raised on enable");
  a_held_quiet: assert property (
    !running [*2] |-> !square_wave_out && !pf_event && !tick_1hz)
    else $error("activity while divider held");
  a_held_half: assert property (
    !running |=> div_q == RTCAD_DIV_HALF || running)
    else $error("divider not preset to half");
  a_sqw_gate: assert property (
    !square_wave_enable |=> !square_wave_out)
    else $error("square wave without enable");
  a_wild_alarm: assert property (
    update_done && running && mem[RTCAD_A_SEC_ALM][7:6] == RTCAD_WILD_TOP
      && mem[RTCAD_A_MIN_ALM][7:6] == RTCAD_WILD_TOP
      && mem[RTCAD_A_HR_ALM][7:6] == RTCAD_WILD_TOP |=> af_q)
    else $error("wildcard alarm missed");
  a_pf_edge: assert property (
    $fell(tap) && running && $past(running) |-> pf_event ##1 pf_q)
    else $error("periodic flag missed");
  a_rate_off: assert property (
    rs_q == RTCAD_RS_OFF |-> !tap ##1 !square_wave_out)
    else $error("output with rate zero");

  c_periodic_irq: cover property (pf_q && periodic_int_enable && irq_oe);
  c_alarm_irq:    cover property (af_event ##1 irq_oe);
  c_read_race:    cover property (flags_read && pf_event);
  c_one_second:   cover property (tick_1hz);

endmodule

// *** verification/rtcad_host.sv ***
// host processor model that drives the register port of the block
`timescale 1ns/1ps
module rtcad_host (
  // clock
  input  wire logic                clk_sys,
  // register port
  output rtcad_pkg::rtcad_bus_type bus,
  input  wire logic [7:0]          rdata
);
  import rtcad_pkg::*;
  // ==========================================================
  // bus cycles
  // idle bus from time zero
  initial begin
    bus = '0;
  end
  // one write cycle; the bench writes only documented divider codes
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    bus <= '0;
    #1;
  endtask
  // one read cycle; data is valid only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    d = rdata;
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the alarm, interrupt and divider block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end \
end
module testbench;
  import rtcad_pkg::*;
  logic           clk_sys, nrst, osc_tick, update_done;
  logic           update_in_progress, ram_valid;
  logic           tick_1hz, irq_oe, square_wave_out, m, alarm_int_enable;
  logic           upd_inh, irq_n;
  logic [5:0]     a;
  logic [7:0]     rdata, v, d, keep;
  rtcad_bus_type  bus;
  rtcad_time_type time_now, t, al;
  int             errors, samples_checked, n;

  rtcad_core rtcad_core_i (
    .clk_sys(clk_sys), .nrst(nrst), .osc_tick(osc_tick), .bus(bus),
    .rdata(rdata), .time_now(time_now),
    .update_in_progress(update_in_progress), .update_done(update_done),
    .ram_valid(ram_valid), .tick_1hz(tick_1hz), .update_inhibit(upd_inh),
    .time_load(), .irq_n_o(irq_n), .irq_oe(irq_oe),
    .square_wave_out(square_wave_out));
  rtcad_host rtcad_host_i (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));

  // 25 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // expectations
  function automatic logic exp_af(rtcad_time_type t, rtcad_time_type a);
    return (a.sec[7:6] == 2'h3 || a.sec == t.sec) &&
           (a.min[7:6] == 2'h3 || a.min == t.min) &&
           (a.hr[7:6] == 2'h3 || a.hr == t.hr);
  endfunction
  // square-wave period in clocks with a time-base tick every clock
  function automatic int exp_period(int dv, int rs);
    int tap;
    tap = (dv == 2 && rs < 3) ? rs + 12 : rs + 5;
    return 1 << (tap + 1 - (dv == 0 ? 0 : (dv == 1 ? 2 : 7)));
  endfunction
  // alarm byte: match, wildcard at either end, or a near miss
  function automatic logic [7:0] pick(logic [7:0] b);
    case ($urandom_range(4))
      0: return 8'hc0;
      1: return 8'hff;
      2: return 8'hbf;
      default: return b;
    endcase
  endfunction
  // ==========================================================
  // helpers
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] ex);
    logic [7:0] r;
    rtcad_host_i.rd(a, r);
    `CHK($sformatf("read %h", a), ex, r)
  endtask
  task automatic pulse_done();
    @(posedge clk_sys);
    update_done <= 1'b1;
    @(posedge clk_sys);
    update_done <= 1'b0;
    #1;
  endtask
  // clocks until the next low-to-high of the square wave
  task automatic rise_gap(output int g);
    g = 0;
    while (square_wave_out !== 1'b0 && g < 9000) begin
      @(posedge clk_sys);
      #1;
      g++;
    end
    while (square_wave_out !== 1'b1 && g < 9000) begin
      @(posedge clk_sys);
      #1;
      g++;
    end
  endtask
  task automatic wait_tick(output int g);
    g = 0;
    do begin
      @(posedge clk_sys);
      #1;
      g++;
    end while (tick_1hz !== 1'b1 && g < 40000);
  endtask
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (98000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    osc_tick = 1'b1;
    update_done = 1'b0;
    update_in_progress = 1'b0;
    ram_valid = 1'b1;
    time_now = '0;
    errors = 0;
    samples_checked = 0;
    n = $urandom(32'hb4e1a77b);
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(RTCAD_A_CTRL_B, 8'h00);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    `CHK("irq_oe", 1'b0, irq_oe)
    // storage with divider held and update logic busy
    update_in_progress <= 1'b1;
    keep = 8'($urandom);
    rtcad_host_i.wr(6'h0e, keep);
    repeat (16) begin
      a = 6'($urandom_range(63, 1));
      if (a >= RTCAD_A_CTRL_A && a <= 6'h0e) a = RTCAD_A_TIME_END;
      d = 8'($urandom);
      rtcad_host_i.wr(a, d);
      rd_chk(a, d);
    end
    rtcad_host_i.wr(RTCAD_A_SEC, 8'hff);
    rd_chk(RTCAD_A_SEC, 8'h7f);
    rtcad_host_i.wr(RTCAD_A_FLAGS, 8'hff);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    update_in_progress <= 1'b0;
    // release divider on the slow base, rate off
    rtcad_host_i.wr(RTCAD_A_CTRL_A, 8'h20);
    wait_tick(n);
    `CHK("first tick", 1'b1, n >= 16383 && n <= 16387)
    wait_tick(n);
    `CHK("tick gap", 32768, n)
    // flags, read clearing and immediate interrupt
    // seconds alarm off the current time so no alarm flag rides along
    rtcad_host_i.wr(RTCAD_A_SEC_ALM, 8'h01);
    pulse_done();
    rd_chk(RTCAD_A_FLAGS, 8'h10);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    fork
      rd_chk(RTCAD_A_FLAGS, 8'h00);
      pulse_done();
    join
    rd_chk(RTCAD_A_FLAGS, 8'h10);
    pulse_done();
    `CHK("irq_oe", 1'b0, irq_oe)
    rtcad_host_i.wr(RTCAD_A_CTRL_B, 8'h10);
    `CHK("irq_oe", 1'b1, irq_oe)
    `CHK("irq pin", 1'b0, irq_n)
    rd_chk(RTCAD_A_FLAGS, 8'h90);
    `CHK("irq_oe", 1'b0, irq_oe)
    // random alarm matching with and without the enable
    repeat (16) begin
      t.sec = 8'($urandom_range(59));
      t.min = 8'($urandom_range(59));
      t.hr = 8'($urandom_range(23));
      al.sec = pick(t.sec);
      al.min = pick(t.min);
      al.hr = pick(t.hr);
      alarm_int_enable = 1'($urandom);
      rtcad_host_i.wr(RTCAD_A_SEC_ALM, al.sec);
      rtcad_host_i.wr(RTCAD_A_MIN_ALM, al.min);
      rtcad_host_i.wr(RTCAD_A_HR_ALM, al.hr);
      rtcad_host_i.wr(RTCAD_A_CTRL_B, {2'h0, alarm_int_enable, 5'h00});
      time_now <= t;
      pulse_done();
      m = exp_af(t, al);
      `CHK("irq_oe", m & alarm_int_enable, irq_oe)
      rd_chk(RTCAD_A_FLAGS, {m & alarm_int_enable, 1'b0, m, 1'b1, 4'h0});
    end
    // square-wave period per base and rate code, for periods up to 1024 clocks
    rtcad_host_i.wr(RTCAD_A_CTRL_B, 8'h08);
    for (int dv = 0; dv < 3; dv++) begin
      for (int rs = 1; rs < 16; rs++) begin
        if (exp_period(dv, rs) <= 1024) begin
          rtcad_host_i.wr(RTCAD_A_CTRL_A, {1'b0, 3'(dv), 4'(rs)});
          repeat (3) rise_gap(n);
          `CHK("sq period", exp_period(dv, rs), n)
        end
      end
    end
    // rate zero gives no periodic flag
    rtcad_host_i.wr(RTCAD_A_CTRL_A, 8'h20);
    rtcad_host_i.rd(RTCAD_A_FLAGS, v);
    repeat (300) @(posedge clk_sys);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    // set bit keeps the square wave running
    rtcad_host_i.wr(RTCAD_A_CTRL_B, 8'h88);
    `CHK("set bit", 1'b1, upd_inh)
    rtcad_host_i.wr(RTCAD_A_CTRL_A, 8'h23);
    repeat (3) rise_gap(n);
    `CHK("sq period set", 4, n)
    // periodic interrupt without the square wave
    rtcad_host_i.wr(RTCAD_A_CTRL_B, 8'h40);
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("sq off", 1'b0, square_wave_out)
    `CHK("irq_oe", 1'b1, irq_oe)
    rd_chk(RTCAD_A_FLAGS, 8'hc0);
    // held divider stops both outputs
    rtcad_host_i.wr(RTCAD_A_CTRL_B, 8'h48);
    rtcad_host_i.wr(RTCAD_A_CTRL_A, 8'h73);
    rtcad_host_i.rd(RTCAD_A_FLAGS, v);
    repeat (50) @(posedge clk_sys);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    `CHK("sq held", 1'b0, square_wave_out)
    `CHK("irq_oe", 1'b0, irq_oe)
    // reset in mid-run with an interrupt pending
    rtcad_host_i.wr(RTCAD_A_CTRL_A, 8'h23);
    repeat (8) @(posedge clk_sys);
    @(posedge clk_sys);
    nrst <= 1'b0;
    #1;
    `CHK("irq_oe", 1'b0, irq_oe)
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(RTCAD_A_CTRL_B, 8'h00);
    rd_chk(RTCAD_A_FLAGS, 8'h00);
    rd_chk(6'h0e, keep);
    wrap_up();
  end
endmodule
